// File: src/dpc_top.sv
// Purpose: system-side power modes, isolation link, calibration and loopback paths
// Assumes: pcm and link pins are asynchronous and sampled by clk
// Notes: registers reached over a byte port with read data one cycle later
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
// Behaviour
// - reset defaults keep line side powered down
// - link idle until link powerdown cleared
// - four power modes from two bits
// - reset defaults give reset operation mode
// - both bits clear: normal link operation
// - chip powerdown alone: sleep, link and ring
// - only reset leaves sleep or full powerdown
// - both bits set: only register reads work, no ring
// - off-hook: resistor cal, settle, adc cal
// - resistor cal disable suppresses resistor cal
// - manual adc cal on trigger falling edge with auto cal disabled
// - link powerdown: pcm loop through filters
// - link enabled: tx from line, frame detect
// - digital loopback returns pcm data unchanged
// - link loopback goes through line side
// - hybrid disabled: flag sent to line side over the link
module dpc_top #(
    parameter int unsigned RCAL_CYCLES = dpc_pkg::RCAL_CYCLES,
    parameter int unsigned SETTLE_CYCLES = dpc_pkg::SETTLE_CYCLES,
    parameter int unsigned ADC_CYCLES = dpc_pkg::ADC_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire dpc_pkg::dpc_reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    input wire dpc_pkg::dpc_pcm_in_type pcm_in,
    output logic pcm_tx_data,
    output logic pcm_tx_oe,
    input wire logic link_clk,
    input wire logic link_rx,
    output logic link_tx,
    output logic link_enable,
    output logic ring_detect_out_n
);
    typedef struct packed {
        logic [7:0] rdata;
        logic link_loopback_enable;
        logic hybrid_enable;
        logic offhook;
        logic chip_powerdown;
        logic link_powerdown;
        logic digital_data_loopback;
        logic manual_cal_trigger;
        logic auto_cal_disable;
        logic resistor_cal_disable;
        logic pcm_analog_loopback;
        logic pclk_d;
        logic pactive;
        logic [2:0] pbit;
        logic [7:0] prx_sh;
        logic [7:0] ptx_sh;
        logic ptx;
        logic ptx_oe;
        logic [7:0] rx_filt;
        logic [7:0] tx_word;
        logic [7:0] to_line;
        logic lclk_d;
        logic [3:0] lbit;
        logic [15:0] lrx_sh;
        logic [15:0] ltx_sh;
        logic ltx;
        logic frame_detect_status;
        logic [7:0] from_line;
        logic ring;
        logic line_power;
        logic ring_n;
    } dpc_top_state_type;

    localparam dpc_top_state_type ST_RST = '{
        link_powerdown: dpc_pkg::LINK_PD_RST,
        chip_powerdown: dpc_pkg::CHIP_PD_RST,
        hybrid_enable: dpc_pkg::HYBRID_RST,
        ring_n: 1'b1,
        default: '0
    };

    dpc_top_state_type st_ff;
    dpc_top_state_type nxt_st;

    logic [4:0] pin_s;
    logic pclk_s;
    logic pcm_frame_sync_s;
    logic drx_s;
    logic lclk_s;
    logic lrx_s;
    logic prise;
    logic lrise;
    logic lfall;
    logic [7:0] pbyte;
    logic [15:0] lword;
    logic power_lost;
    logic cal_busy;
    dpc_pkg::dpc_pmode_type pmode;

    // 0.9 dB loss of the filter path, about 1 - 1/8 + 1/32
    function automatic logic [7:0] atten(input logic [7:0] x);
        logic signed [7:0] v;
        v = signed'(x);
        atten = 8'(v - (v >>> dpc_pkg::ATT_SH1) + (v >>> dpc_pkg::ATT_SH2));
    endfunction

    dpc_sync #(
        .W(5)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d({pcm_in.clk, pcm_in.frame_sync, pcm_in.rx_data, link_clk, link_rx}),
        .q(pin_s)
    );

    assign pclk_s = pin_s[4];
    assign pcm_frame_sync_s = pin_s[3];
    assign drx_s = pin_s[2];
    assign lclk_s = pin_s[1];
    assign lrx_s = pin_s[0];

    dpc_cal_seq #(
        .RCAL_CYC(RCAL_CYCLES),
        .SETTLE_CYC(SETTLE_CYCLES),
        .ADC_CYC(ADC_CYCLES)
    ) u_cal (
        .clk(clk),
        .rst(rst),
        .offhook(st_ff.offhook & ~st_ff.link_powerdown),
        .power_lost(power_lost),
        .resistor_cal_disable(st_ff.resistor_cal_disable),
        .auto_cal_disable(st_ff.auto_cal_disable),
        .manual_cal_trigger(st_ff.manual_cal_trigger),
        .busy(cal_busy)
    );

    always_comb
    begin
        nxt_st = st_ff;
        pmode = dpc_pkg::dpc_pmode_type'({st_ff.chip_powerdown, st_ff.link_powerdown});
        prise = pclk_s & ~st_ff.pclk_d;
        lrise = lclk_s & ~st_ff.lclk_d;
        lfall = ~lclk_s & st_ff.lclk_d;
        pbyte = {st_ff.prx_sh[6:0], drx_s};
        lword = {st_ff.lrx_sh[14:0], lrx_s};
        power_lost = 1'b0;
        nxt_st.pclk_d = pclk_s;
        nxt_st.lclk_d = lclk_s;

        // register port; writes are dropped while the chip is powered down
        nxt_st.rdata = '0;
        if (reg_req.wr && !st_ff.chip_powerdown)
        begin
            case (reg_req.addr)
                dpc_pkg::REG_LINK_LOOP:
                    nxt_st.link_loopback_enable = reg_req.wdata[dpc_pkg::BIT_LINK_LOOP];
                dpc_pkg::REG_HYBRID:
                    nxt_st.hybrid_enable = reg_req.wdata[dpc_pkg::BIT_HYBRID];
                dpc_pkg::REG_HOOK:
                    nxt_st.offhook = reg_req.wdata[dpc_pkg::BIT_OFFHOOK];
                dpc_pkg::REG_POWER:
                begin
                    nxt_st.chip_powerdown = reg_req.wdata[dpc_pkg::BIT_CHIP_PD];
                    nxt_st.link_powerdown = reg_req.wdata[dpc_pkg::BIT_LINK_PD];
                end
                dpc_pkg::REG_DIG_LOOP:
                    nxt_st.digital_data_loopback = reg_req.wdata[dpc_pkg::BIT_DIG_LOOP];
                dpc_pkg::REG_CAL:
                begin
                    nxt_st.manual_cal_trigger = reg_req.wdata[dpc_pkg::BIT_CAL_MANUAL];
                    nxt_st.auto_cal_disable = reg_req.wdata[dpc_pkg::BIT_CAL_AUTO_DIS];
                end
                dpc_pkg::REG_RCAL:
                    nxt_st.resistor_cal_disable = reg_req.wdata[dpc_pkg::BIT_RCAL_DIS];
                dpc_pkg::REG_PCM_LOOP:
                    nxt_st.pcm_analog_loopback = reg_req.wdata[dpc_pkg::BIT_PCM_LOOP];
                default:
                    nxt_st.rdata = '0;
            endcase
        end
        if (reg_req.rd)
        begin
            case (reg_req.addr)
                dpc_pkg::REG_LINK_LOOP:
                    nxt_st.rdata[dpc_pkg::BIT_LINK_LOOP] = st_ff.link_loopback_enable;
                dpc_pkg::REG_HYBRID:
                    nxt_st.rdata[dpc_pkg::BIT_HYBRID] = st_ff.hybrid_enable;
                dpc_pkg::REG_HOOK:
                    nxt_st.rdata[dpc_pkg::BIT_OFFHOOK] = st_ff.offhook;
                dpc_pkg::REG_POWER:
                begin
                    nxt_st.rdata[dpc_pkg::BIT_CHIP_PD] = st_ff.chip_powerdown;
                    nxt_st.rdata[dpc_pkg::BIT_LINK_PD] = st_ff.link_powerdown;
                end
                dpc_pkg::REG_DIG_LOOP:
                    nxt_st.rdata[dpc_pkg::BIT_DIG_LOOP] = st_ff.digital_data_loopback;
                dpc_pkg::REG_STATUS:
                begin
                    nxt_st.rdata[dpc_pkg::BIT_FDT] = st_ff.frame_detect_status;
                    nxt_st.rdata[dpc_pkg::BIT_RING_STAT] = st_ff.ring & st_ff.frame_detect_status;
                    nxt_st.rdata[dpc_pkg::BIT_LINE_PWR] = st_ff.line_power & st_ff.frame_detect_status;
                end
                dpc_pkg::REG_CAL:
                begin
                    nxt_st.rdata[dpc_pkg::BIT_CAL_MANUAL] = st_ff.manual_cal_trigger;
                    nxt_st.rdata[dpc_pkg::BIT_CAL_AUTO_DIS] = st_ff.auto_cal_disable;
                    nxt_st.rdata[dpc_pkg::BIT_CAL_BUSY] = cal_busy;
                end
                dpc_pkg::REG_RCAL:
                    nxt_st.rdata[dpc_pkg::BIT_RCAL_DIS] = st_ff.resistor_cal_disable;
                dpc_pkg::REG_PCM_LOOP:
                    nxt_st.rdata[dpc_pkg::BIT_PCM_LOOP] = st_ff.pcm_analog_loopback;
                default:
                    nxt_st.rdata = '0;
            endcase
        end

        // pcm highway, only while the chip is not powered down
        if (st_ff.chip_powerdown)
        begin
            nxt_st.pactive = 1'b0;
            nxt_st.ptx = 1'b0;
            nxt_st.ptx_oe = 1'b0;
        end
        else if (prise)
        begin
            if (pcm_frame_sync_s)
            begin
                nxt_st.pactive = 1'b1;
                nxt_st.pbit = '0;
                nxt_st.prx_sh = {7'h00, drx_s};
                nxt_st.ptx = st_ff.tx_word[7];
                nxt_st.ptx_sh = {st_ff.tx_word[6:0], 1'b0};
                nxt_st.ptx_oe = 1'b1;
            end
            else if (st_ff.pactive)
            begin
                nxt_st.prx_sh = pbyte;
                nxt_st.pbit = st_ff.pbit + 1'b1;
                nxt_st.ptx = st_ff.ptx_sh[7];
                nxt_st.ptx_sh = {st_ff.ptx_sh[6:0], 1'b0};
                if (st_ff.pbit + 1'b1 == dpc_pkg::PCM_LAST)
                begin
                    nxt_st.pactive = 1'b0;
                    if (st_ff.digital_data_loopback)
                        nxt_st.tx_word = pbyte;
                    else if (st_ff.link_powerdown)
                    begin
                        nxt_st.rx_filt = atten(pbyte);
                        nxt_st.tx_word = st_ff.rx_filt;
                    end
                    else if (st_ff.pcm_analog_loopback)
                        nxt_st.tx_word = st_ff.from_line;
                    else
                    begin
                        nxt_st.to_line = atten(pbyte);
                        nxt_st.tx_word = st_ff.from_line;
                    end
                end
            end
            else
            begin
                nxt_st.ptx = 1'b0;
                nxt_st.ptx_oe = 1'b0;
            end
        end

        // isolation link
        if (st_ff.link_powerdown)
        begin
            nxt_st.lbit = '0;
            nxt_st.lrx_sh = '0;
            nxt_st.ltx_sh = '0;
            nxt_st.ltx = 1'b0;
            nxt_st.frame_detect_status = 1'b0;
            nxt_st.ring = 1'b0;
            nxt_st.line_power = 1'b0;
        end
        else
        begin
            if (lrise)
            begin
                nxt_st.lrx_sh = lword;
                if (st_ff.lbit == dpc_pkg::LINK_LAST)
                begin
                    // on a bad sync the window slides one bit and checks again
                    if (lword[15:12] == dpc_pkg::LINK_RX_SYNC)
                    begin
                        nxt_st.frame_detect_status = 1'b1;
                        nxt_st.ring = lword[dpc_pkg::LRX_RING];
                        nxt_st.line_power = lword[dpc_pkg::LRX_POWER];
                        power_lost = st_ff.frame_detect_status & st_ff.line_power & ~lword[dpc_pkg::LRX_POWER];
                        nxt_st.lbit = '0;
                        if (st_ff.pcm_analog_loopback && !st_ff.digital_data_loopback)
                        begin
                            nxt_st.rx_filt = atten(lword[7:0]);
                            nxt_st.to_line = atten(st_ff.rx_filt);
                            nxt_st.from_line = lword[7:0];
                        end
                        else
                            nxt_st.from_line = atten(lword[7:0]);
                        nxt_st.ltx_sh = {dpc_pkg::LINK_TX_SYNC, st_ff.offhook, st_ff.hybrid_enable,
                                         st_ff.link_loopback_enable, 1'b0, st_ff.to_line};
                    end
                    else
                        nxt_st.frame_detect_status = 1'b0;
                end
                else
                    nxt_st.lbit = st_ff.lbit + 1'b1;
            end
            if (lfall)
            begin
                nxt_st.ltx = st_ff.ltx_sh[15];
                nxt_st.ltx_sh = {st_ff.ltx_sh[14:0], 1'b0};
            end
        end

        // ring output only with a live link and not in full powerdown
        nxt_st.ring_n = ~(st_ff.ring & st_ff.frame_detect_status & (pmode != dpc_pkg::PM_FULL_PD));
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_ff <= ST_RST;
        else
            st_ff <= nxt_st;
    end

    assign reg_rdata = st_ff.rdata;
    assign pcm_tx_data = st_ff.ptx;
    assign pcm_tx_oe = st_ff.ptx_oe;
    assign link_tx = st_ff.ltx;
    assign link_enable = ~st_ff.link_powerdown;
    assign ring_detect_out_n = st_ff.ring_n;
endmodule

// File: src/dpc_pkg.sv
// Purpose: shared constants and types of the power, calibration and loopback control
// Assumes: 25 MHz system clock, byte-wide register port
// Notes: times are in microseconds, cycle counts are derived from them
package dpc_pkg;
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned RCAL_TIME_US = 17000;
    localparam int unsigned SETTLE_TIME_US = 129750;
    localparam int unsigned ADC_TIME_US = 256000;
    localparam int unsigned RCAL_CYCLES = RCAL_TIME_US * CLK_MHZ;
    localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
    localparam int unsigned ADC_CYCLES = ADC_TIME_US * CLK_MHZ;
    localparam int CNT_W = 23;

    // register addresses
    localparam logic [7:0] REG_LINK_LOOP = 8'h01;
    localparam logic [7:0] REG_HYBRID = 8'h02;
    localparam logic [7:0] REG_HOOK = 8'h05;
    localparam logic [7:0] REG_POWER = 8'h06;
    localparam logic [7:0] REG_DIG_LOOP = 8'h0a;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_CAL = 8'h11;
    localparam logic [7:0] REG_RCAL = 8'h19;
    localparam logic [7:0] REG_PCM_LOOP = 8'h21;

    // field positions
    localparam int BIT_LINK_LOOP = 1;
    localparam int BIT_HYBRID = 1;
    localparam int BIT_OFFHOOK = 0;
    localparam int BIT_CHIP_PD = 3;
    localparam int BIT_LINK_PD = 4;
    localparam int BIT_DIG_LOOP = 0;
    localparam int BIT_RING_STAT = 0;
    localparam int BIT_LINE_PWR = 1;
    localparam int BIT_FDT = 6;
    localparam int BIT_CAL_MANUAL = 3;
    localparam int BIT_CAL_AUTO_DIS = 4;
    localparam int BIT_CAL_BUSY = 7;
    localparam int BIT_RCAL_DIS = 5;
    localparam int BIT_PCM_LOOP = 7;

    // reset values of control bits
    localparam logic LINK_PD_RST = 1'b1;
    localparam logic CHIP_PD_RST = 1'b0;
    localparam logic HYBRID_RST = 1'b1;

    // serial framing and filter shifts
    localparam logic [2:0] PCM_LAST = 3'h7;
    localparam logic [3:0] LINK_LAST = 4'hf;
    localparam logic [3:0] LINK_TX_SYNC = 4'ha;
    localparam logic [3:0] LINK_RX_SYNC = 4'h5;
    localparam int LRX_RING = 11;
    localparam int LRX_POWER = 10;
    localparam int ATT_SH1 = 3;
    localparam int ATT_SH2 = 5;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RES = 2'b01,
        CAL_SETTLE = 2'b10,
        CAL_ADC = 2'b11
    } dpc_cal_state_type;

    // {chip_powerdown, link_powerdown}
    typedef enum logic [1:0] {
        PM_NORMAL = 2'b00,
        PM_RESET_OP = 2'b01,
        PM_SLEEP = 2'b10,
        PM_FULL_PD = 2'b11
    } dpc_pmode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dpc_reg_req_type;

    typedef struct packed {
        logic clk;
        logic frame_sync;
        logic rx_data;
    } dpc_pcm_in_type;
endpackage

// File: src/dpc_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: one clock
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module dpc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dpc_sync_state_type;

    dpc_sync_state_type st_ff;
    dpc_sync_state_type nxt_st;

    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            nxt_st.s1[i] = d[i];
            nxt_st.s2[i] = st_ff.s1[i];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign q = st_ff.s2;
endmodule

// File: src/dpc_cal_seq.sv
// Purpose: resistor, settle and adc calibration sequencer
// Assumes: counts given in system clock cycles
// Notes: going on-hook aborts an automatic sequence in its resistor or settle stage, not in its adc stage
`timescale 1ns/100ps
module dpc_cal_seq #(
    parameter int unsigned RCAL_CYC = dpc_pkg::RCAL_CYCLES,
    parameter int unsigned SETTLE_CYC = dpc_pkg::SETTLE_CYCLES,
    parameter int unsigned ADC_CYC = dpc_pkg::ADC_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic offhook,
    input wire logic power_lost,
    input wire logic resistor_cal_disable,
    input wire logic auto_cal_disable,
    input wire logic manual_cal_trigger,
    output logic busy
);
    localparam int CW = dpc_pkg::CNT_W;
    localparam logic [CW-1:0] RCAL_LD = CW'(RCAL_CYC - 1);
    localparam logic [CW-1:0] SETTLE_LD = CW'(SETTLE_CYC - 1);
    localparam logic [CW-1:0] ADC_LD = CW'(ADC_CYC - 1);

    typedef struct packed {
        dpc_pkg::dpc_cal_state_type state;
        logic [CW-1:0] cnt;
        logic hook_d;
        logic manual_cal_trigger_d;
    } dpc_cal_state_reg_type;

    dpc_cal_state_reg_type st_ff;
    dpc_cal_state_reg_type nxt_st;

    logic auto_start;
    logic manual_start;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.hook_d = offhook;
        nxt_st.manual_cal_trigger_d = manual_cal_trigger;
        auto_start = (offhook & ~st_ff.hook_d) | (power_lost & offhook);
        manual_start = st_ff.manual_cal_trigger_d & ~manual_cal_trigger & auto_cal_disable;
        if (st_ff.cnt != '0)
            nxt_st.cnt = st_ff.cnt - 1'b1;
        if (auto_start)
        begin
            if (!resistor_cal_disable)
            begin
                nxt_st.state = dpc_pkg::CAL_RES;
                nxt_st.cnt = RCAL_LD;
            end
            else
            begin
                nxt_st.state = dpc_pkg::CAL_SETTLE;
                nxt_st.cnt = SETTLE_LD;
            end
        end
        else
        begin
            case (st_ff.state)
                dpc_pkg::CAL_IDLE:
                begin
                    if (manual_start)
                    begin
                        nxt_st.state = dpc_pkg::CAL_ADC;
                        nxt_st.cnt = ADC_LD;
                    end
                end
                dpc_pkg::CAL_RES:
                begin
                    if (!offhook)
                        nxt_st.state = dpc_pkg::CAL_IDLE;
                    else if (st_ff.cnt == '0)
                    begin
                        nxt_st.state = dpc_pkg::CAL_SETTLE;
                        nxt_st.cnt = SETTLE_LD;
                    end
                end
                dpc_pkg::CAL_SETTLE:
                begin
                    if (!offhook || (st_ff.cnt == '0 && auto_cal_disable))
                        nxt_st.state = dpc_pkg::CAL_IDLE;
                    else if (st_ff.cnt == '0)
                    begin
                        nxt_st.state = dpc_pkg::CAL_ADC;
                        nxt_st.cnt = ADC_LD;
                    end
                end
                dpc_pkg::CAL_ADC:
                begin
                    if (st_ff.cnt == '0)
                        nxt_st.state = dpc_pkg::CAL_IDLE;
                end
                default:
                    nxt_st.state = dpc_pkg::CAL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_ff <= '{state: dpc_pkg::CAL_IDLE, default: '0};
        else
            st_ff <= nxt_st;
    end

    assign busy = (st_ff.state != dpc_pkg::CAL_IDLE);
endmodule

// File: sim/dpc_top_properties.sv
// Purpose: port checks of power modes, link gating and status reads
// Assumes: register writes act one cycle after the strobe
// Notes: chip powerdown is tracked from the writes seen
`timescale 1ns/100ps
module dpc_top_properties (
    input wire logic clk,
    input wire logic rst,
    input wire dpc_pkg::dpc_reg_req_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic pcm_tx_data,
    input wire logic pcm_tx_oe,
    input wire logic link_tx,
    input wire logic link_enable,
    input wire logic ring_detect_out_n
);
    logic pd_ff;
    logic pd2_ff;
    logic pw;
    assign pw = reg_req.wr && reg_req.addr == dpc_pkg::REG_POWER;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pd_ff <= 1'b0;
            pd2_ff <= 1'b0;
        end
        else
        begin
            if (pw && !pd_ff)
                pd_ff <= reg_req.wdata[dpc_pkg::BIT_CHIP_PD];
            pd2_ff <= pd_ff;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_defaults: assert property ($fell(rst) |-> !link_enable && ring_detect_out_n && !pcm_tx_oe)
        else $error("reset state wrong");
    a_link_quiet: assert property (!link_enable && !$past(link_enable) |-> !link_tx)
        else $error("link active while down");
    a_mode_write: assert property (pw && !pd_ff |=> link_enable == !$past(reg_req.wdata[4]))
        else $error("link enable not from write");
    a_sleep_frozen: assert property (pd_ff && reg_req.wr |=> $stable(link_enable))
        else $error("write taken in powerdown");
    a_sleep_silent: assert property (pd2_ff |-> !pcm_tx_oe && !pcm_tx_data)
        else $error("pcm driven in powerdown");
    a_full_pd_ring: assert property (pd2_ff && !link_enable |-> ring_detect_out_n)
        else $error("ring in full powerdown");
    a_mode_readback: assert property ($past(reg_req.rd) && $past(reg_req.addr) == dpc_pkg::REG_POWER
        |-> reg_rdata[4] != link_enable)
        else $error("power read mismatch");
    a_fdt_off: assert property ($past(reg_req.rd) && $past(reg_req.addr) == dpc_pkg::REG_STATUS
        && !$past(link_enable) && !$past(link_enable, 2) |-> !reg_rdata[6])
        else $error("frame detect without link");
    c_fdt: cover property ($past(reg_req.rd) && reg_rdata[6]);
    c_sleep: cover property (pd2_ff && link_enable);
    c_full: cover property (pd2_ff && !link_enable);
endmodule
bind dpc_top dpc_top_properties u_props (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pcm_tx_data(pcm_tx_data), .pcm_tx_oe(pcm_tx_oe), .link_tx(link_tx), .link_enable(link_enable),
    .ring_detect_out_n(ring_detect_out_n));

// File: sim/dpc_line_model.sv
// Purpose: line side companion sending link frames
// Assumes: link clock only while the link is enabled
// Notes: line powered, ringing, fixed data byte
`timescale 1ns/100ps
module dpc_line_model (
    input wire logic link_enable,
    output logic link_clk,
    output logic link_rx
);
    logic [15:0] frame = {4'h5, 1'b1, 1'b1, 2'b00, 8'h40};
    initial
    begin
        link_clk = 1'b0;
        link_rx = 1'b0;
        #7;
        forever
        begin
            if (!link_enable)
            begin
                link_rx = ~link_rx; // toggling line, no stale value
                #160;
            end
            else
                for (int i = 15; i >= 0; i--)
                begin
                    link_rx = frame[i];
                    #160 link_clk = 1'b1;
                    #160 link_clk = 1'b0;
                end
        end
    end
endmodule

// File: sim/dpc_top_tb.sv
// Purpose: self-checking bench of the power, calibration and loopback control
// Assumes: short calibration counts 20, 30 and 40
// Notes: pcm bit clock is 16 system cycles long
`timescale 1ns/100ps
module dpc_top_tb;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dpc_row_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    dpc_pkg::dpc_reg_req_type req = '0;
    dpc_pkg::dpc_pcm_in_type pcm = '0;
    logic [7:0] rdata, got;
    logic ptx, poe, lclk, lrx, ltx, len, ring_n;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    // each test mode but resistor cal disable and digital loopback is cleared again before the next one is set
    dpc_row_type rows [9] = '{'{8'h01, 8'h02, 8'h02}, '{8'h01, 8'h00, 8'h00}, '{8'h02, 8'h00, 8'h00},
        '{8'h02, 8'h02, 8'h02}, '{8'h21, 8'h80, 8'h80}, '{8'h21, 8'h00, 8'h00}, '{8'h19, 8'h20, 8'h20},
        '{8'h3f, 8'hff, 8'h00}, '{8'h0a, 8'h01, 8'h01}};
    dpc_top #(.RCAL_CYCLES(20), .SETTLE_CYCLES(30), .ADC_CYCLES(40)) uut (.clk(clk), .rst(rst),
        .reg_req(req), .reg_rdata(rdata), .pcm_in(pcm), .pcm_tx_data(ptx), .pcm_tx_oe(poe),
        .link_clk(lclk), .link_rx(lrx), .link_tx(ltx), .link_enable(len), .ring_detect_out_n(ring_n));
    dpc_line_model line (.link_enable(len), .link_clk(lclk), .link_rx(lrx));
    always #20 clk = ~clk;
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic chk(input string s, input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", s, e, g);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) req <= '0;
        #1 got = rdata;
    endtask
    task automatic frame(input logic [7:0] x);
        @(posedge clk);
        for (int i = 7; i >= 0; i--)
        begin
            pcm <= '{1'b0, i == 7, x[i]};
            repeat (8) @(posedge clk);
            pcm.clk <= 1'b1;
            repeat (8) @(posedge clk);
            got[i] = ptx;
        end
    endtask
    function automatic logic [7:0] att(input logic [7:0] x);
        return x - {{3{x[7]}}, x[7:3]} + {{5{x[7]}}, x[7:5]};
    endfunction
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[k])
        begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a);
            chk("reg", got, rows[k].e);
        end
        $display("test regs done");
        frame(8'ha5);
        frame(8'h3c);
        chk("ddl", got, 8'ha5);
        chk("oe", {7'h00, poe}, 8'h01);
        wr(8'h0a, 8'h00);
        repeat (3) frame(8'h94);
        chk("filter", got, att(8'h94));
        $display("test pcm done");
        wr(8'h06, 8'h00); // line side powers up last
        chk("link", {7'h00, len}, 8'h01);
        for (int n = 0; n < 100 && got[6] !== 1'b1; n++) // line status used only with frame detect
            rd(8'h0c);
        chk("status", got, 8'h43);
        repeat (2) frame(8'h94);
        chk("line", got, att(8'h40));
        wr(8'h05, 8'h01); // off-hook only with the link up
        repeat (55) @(posedge clk);
        rd(8'h11);
        chk("busy", got & 8'h80, 8'h80);
        repeat (20) @(posedge clk);
        rd(8'h11);
        chk("idle", got & 8'h80, 8'h00);
        wr(8'h11, 8'h10);
        wr(8'h11, 8'h18);
        wr(8'h11, 8'h10);
        repeat (25) @(posedge clk);
        rd(8'h11);
        chk("mbusy", got, 8'h90);
        repeat (25) @(posedge clk);
        rd(8'h11);
        chk("midle", got, 8'h10);
        wr(8'h02, 8'h00);
        repeat (2) frame(8'he5); // transmit level 0.9 dB down
        chk("hybrid_loop", got, att(8'h40));
        wr(8'h02, 8'h02);
        $display("test cal done");
        wr(8'h06, 8'h08);
        frame(8'h5a);
        chk("sleep", {got[6:0], poe}, 8'h00);
        chk("sleep_ring", {7'h00, ring_n}, 8'h00);
        wr(8'h06, 8'h10);
        chk("locked", {7'h00, len}, 8'h01);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h06);
        chk("power", got, 8'h10);
        rd(8'h02);
        chk("hybrid", got, 8'h02);
        rd(8'h0c);
        chk("nolink", got, 8'h00);
        wr(8'h06, 8'h18);
        wr(8'h06, 8'h00);
        repeat (3) @(posedge clk);
        chk("fullpd", {6'h00, len, ring_n}, 8'h01);
        $display("test power done");
        end_of_test();
    end
endmodule
